// ---- common/sccu_regs.svh ----
// Function
// R1: break finishes running measurement, then leaves periodic mode, within 15 ms.
// R2: master should send break before other commands, fetch excepted.
// R3: system reset from soft reset command, reset pin low pulse, power-up.
// R4: commands are ignored while the reset procedure runs.
// R5: nine SCL pulses with SDA high, then START, reset the serial interface; code resets it on the ninth pulse, without waiting for START.
// R6: interface recovery keeps status word and touches nothing else.
// R7: soft reset 0x30A2 when idle resets controller and reloads calibration.
// R8: calibration data reloads before every measurement.
// R9: general call 0x00 then 0x06 resets like the pin, when traffic works.
// R10: external reset pin must stay low at least 350 ns.
// R11: heater on by 0x306D, off by 0x3066.
// R12: heater off after any reset; status bit 13 shows heater state.
// R13: command 0xF32D returns status word MSB first plus CRC on next read.
// R14: clear-status 0x3041 zeroes status bits 15, 10 and 4.
// R15: status bit 15 set while an alert is pending; reset value one.
// R16: status bit 4 set by any reset, held until clear-status.
// R17: status bit 1 set on rejected command, cleared on successful one.
// R18: status bit 0 shows checksum result of last write transfer.
// R19: reserved status bits read zero.
// R20: each data word carries CRC-8, poly 0x31, init 0xFF, no reflection.
// R21: temperature leaves as 16-bit unsigned compensated raw value.
// R22: consumer converts raw value to degrees with offset and factor.
// R23: command is START, write header, two bytes, each byte acknowledged.
// R24: on reads, device stops sending after a byte not acknowledged.
// R25: command cut by STOP before two bytes is discarded.
// R26: disallowed commands during periodic mode set command-status error bit.
`ifndef SCCU_REGS_SVH
`define SCCU_REGS_SVH
`define SCCU_CMD_SOFT_RESET 16'h30a2
`define SCCU_CMD_HEATER_ON 16'h306d
`define SCCU_CMD_HEATER_OFF 16'h3066
`define SCCU_CMD_READ_STATUS 16'hf32d
`define SCCU_CMD_CLEAR_STATUS 16'h3041
`define SCCU_GC_ADDR 7'h00
`define SCCU_GC_RESET 8'h06
`define SCCU_CRC_POLY 8'h31
`define SCCU_CRC_INIT 8'hff
`define SCCU_CRC_XOROUT 8'h00
`define SCCU_ST_ALERT 15
`define SCCU_ST_HEATER 13
`define SCCU_ST_TRACK 10
`define SCCU_ST_RESET 4
`define SCCU_ST_CMD 1
`define SCCU_ST_WCRC 0
`define SCCU_CLK_NS 10
`define SCCU_RSTPIN_MIN_NS 350
`define SCCU_RSTPIN_CYC ((`SCCU_RSTPIN_MIN_NS + `SCCU_CLK_NS - 1) / `SCCU_CLK_NS)
`define SCCU_BREAK_MAX_MS 15
`define SCCU_BREAK_CYC (`SCCU_BREAK_MAX_MS * 1000000 / `SCCU_CLK_NS)
`define SCCU_RECOVER_PULSES 9
`endif

// ---- common/sccu_pkg.sv ----
package sccu_pkg;
    // serial link phases
    typedef enum logic [2:0] {
        SCCU_IDLE, SCCU_ADDR, SCCU_ACK, SCCU_RX, SCCU_TX, SCCU_TX_ACK, SCCU_SKIP
    } sccu_link_st_t;
endpackage : sccu_pkg

// ---- hw/sccu_crc8.sv ----
`timescale 1ns/1ps
`include "sccu_regs.svh"
module sccu_crc8 (
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic [15:0] word_i,
    output logic [7:0] crc_o
);
    logic [7:0] crc_r;
    logic [7:0] crc_nxt;

    // msb-first crc-8 over one word
    function automatic logic [7:0] sccu_crc_word(input logic [15:0] w);
        logic [7:0] c;
        c = `SCCU_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `SCCU_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c ^ `SCCU_CRC_XOROUT;
    endfunction : sccu_crc_word

    always_comb begin
        crc_nxt = sccu_crc_word(word_i); // R20
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc_o = crc_r;
endmodule : sccu_crc8

// ---- hw/sccu_core.sv ----
`timescale 1ns/1ps
`include "sccu_regs.svh"
module sccu_core import sccu_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h45,
    parameter logic [15:0] BREAK_CMD = 16'h0001,
    parameter logic [15:0] FETCH_CMD = 16'h0002,
    parameter int RST_DUR = 16,
    parameter int BREAK_CYC = `SCCU_BREAK_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic ext_reset_low_i,
    input wire logic periodic_i,
    input wire logic meas_busy_i,
    input wire logic meas_start_i,
    input wire logic alert_i,
    input wire logic track_alert_i,
    input wire logic [15:0] temp_word_i,
    output logic [15:0] status_o,
    output logic heater_on_o,
    output logic sys_reset_o,
    output logic cal_reload_o,
    output logic leave_periodic_o,
    output logic intf_reset_o,
    output logic [15:0] cmd_o,
    output logic cmd_valid_o,
    output logic [15:0] wr_word_o,
    output logic wr_valid_o
);
    localparam logic [3:0] REC_LAST = 4'(`SCCU_RECOVER_PULSES - 1);
    localparam logic [5:0] PIN_CYC = 6'(`SCCU_RSTPIN_CYC);
    localparam logic [7:0] RST_LEN = 8'(RST_DUR);
    localparam logic [20:0] BRK_LAST = 21'(BREAK_CYC - 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, rstn_s1, rstn_s2;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {rstn_s1, rstn_s2} <= 2'h3;
        end else if (ce_i) begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
            {rstn_s1, rstn_s2} <= {ext_reset_low_i, rstn_s1};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    sccu_link_st_t st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt, rec_r, rec_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, wcrc_r, wcrc_nxt;
    logic [15:0] cmd_r, cmd_nxt, data_r, data_nxt, txw_r, txw_nxt;
    logic gc_r, gc_nxt, rd_r, rd_nxt, drv_r, drv_nxt;
    logic done_r, done_nxt, gcrst_r, gcrst_nxt, wchk_r, wchk_nxt, rec_p_r, rec_p_nxt;
    logic [7:0] tx_crc, rx_crc, tx_byte;
    logic busy, rd_status_r;

    sccu_crc8 u_tx_crc (.mclk_i(mclk_i), .ce_i(ce_i), .word_i(txw_r), .crc_o(tx_crc));
    sccu_crc8 u_rx_crc (.mclk_i(mclk_i), .ce_i(ce_i), .word_i(data_r), .crc_o(rx_crc));

    // byte sent at each read position: msb, lsb, crc
    always_comb begin
        if (idx_r == 3'h0) begin
            tx_byte = txw_r[15:8]; // R13
        end else if (idx_r == 3'h1) begin
            tx_byte = txw_r[7:0];
        end else begin
            tx_byte = tx_crc; // R20
        end
    end

    // link next state
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        rec_nxt = rec_r;
        idx_nxt = idx_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        wcrc_nxt = wcrc_r;
        cmd_nxt = cmd_r;
        data_nxt = data_r;
        txw_nxt = txw_r;
        gc_nxt = gc_r;
        rd_nxt = rd_r;
        drv_nxt = drv_r;
        done_nxt = 1'b0;
        gcrst_nxt = 1'b0;
        wchk_nxt = 1'b0;
        rec_p_nxt = 1'b0;
        if (scl_rise) begin
            rec_nxt = sda_s2 ? ((rec_r > REC_LAST) ? rec_r : rec_r + 4'h1) : 4'h0;
        end
        if (bus_start) begin
            st_nxt = SCCU_ADDR;
            bit_nxt = 4'h0;
            idx_nxt = 3'h0;
            drv_nxt = 1'b0;
            rec_nxt = 4'h0;
        end else if (bus_stop) begin
            st_nxt = SCCU_IDLE; // R25
            drv_nxt = 1'b0;
        end else if (scl_rise && sda_s2 && rec_r == REC_LAST) begin
            st_nxt = SCCU_IDLE; // R5
            drv_nxt = 1'b0;
            rec_p_nxt = 1'b1;
        end else begin
            case (st_r)
                SCCU_ADDR: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s2};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        bit_nxt = 4'h0;
                        gc_nxt = sh_r[7:1] == `SCCU_GC_ADDR;
                        rd_nxt = sh_r[0];
                        txw_nxt = rd_status_r ? status_o : temp_word_i; // R21
                        if (!busy && (sh_r[7:1] == DEV_ADDR ||
                                (sh_r[7:1] == `SCCU_GC_ADDR && !sh_r[0]))) begin
                            st_nxt = SCCU_ACK; // R23
                            drv_nxt = 1'b1;
                        end else begin
                            st_nxt = SCCU_SKIP; // R4
                        end
                    end
                end
                SCCU_ACK: begin
                    if (scl_fall) begin
                        bit_nxt = 4'h1;
                        st_nxt = rd_r ? SCCU_TX : SCCU_RX;
                        drv_nxt = rd_r & ~tx_byte[7];
                        tx_nxt = {tx_byte[6:0], 1'b0};
                        if (!rd_r) begin
                            bit_nxt = 4'h0;
                        end
                    end
                end
                SCCU_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s2};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        bit_nxt = 4'h0;
                        st_nxt = SCCU_ACK;
                        drv_nxt = 1'b1;
                        idx_nxt = idx_r + 3'h1;
                        if (busy || idx_r > 3'h4 || (gc_r && idx_r != 3'h0)) begin
                            st_nxt = SCCU_SKIP; // R4
                            drv_nxt = 1'b0;
                        end else if (gc_r) begin
                            gcrst_nxt = sh_r == `SCCU_GC_RESET; // R9
                            st_nxt = (sh_r == `SCCU_GC_RESET) ? SCCU_ACK : SCCU_SKIP;
                            drv_nxt = sh_r == `SCCU_GC_RESET;
                        end else if (idx_r == 3'h0) begin
                            cmd_nxt[15:8] = sh_r;
                        end else if (idx_r == 3'h1) begin
                            cmd_nxt[7:0] = sh_r;
                            done_nxt = 1'b1; // R25
                        end else if (idx_r == 3'h2) begin
                            data_nxt[15:8] = sh_r;
                        end else if (idx_r == 3'h3) begin
                            data_nxt[7:0] = sh_r;
                        end else begin
                            wcrc_nxt = sh_r;
                            wchk_nxt = 1'b1; // R18
                        end
                    end
                end
                SCCU_TX: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            drv_nxt = 1'b0;
                            st_nxt = SCCU_TX_ACK;
                        end else begin
                            drv_nxt = ~tx_r[7];
                            tx_nxt = {tx_r[6:0], 1'b0};
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                end
                SCCU_TX_ACK: begin
                    if (scl_rise) begin
                        idx_nxt = idx_r + 3'h1;
                        st_nxt = (sda_s2 || idx_r == 3'h2) ? SCCU_SKIP : SCCU_ACK; // R24
                    end
                end
                default: begin
                    drv_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= SCCU_IDLE;
            bit_r <= 4'h0;
            rec_r <= 4'h0;
            idx_r <= 3'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            wcrc_r <= 8'h00;
            cmd_r <= 16'h0000;
            data_r <= 16'h0000;
            txw_r <= 16'h0000;
            {gc_r, rd_r, drv_r, done_r, gcrst_r, wchk_r, rec_p_r} <= 7'h00;
        end else if (ce_i) begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            rec_r <= rec_nxt;
            idx_r <= idx_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            wcrc_r <= wcrc_nxt;
            cmd_r <= cmd_nxt;
            data_r <= data_nxt;
            txw_r <= txw_nxt;
            {gc_r, rd_r, drv_r, done_r} <= {gc_nxt, rd_nxt, drv_nxt, done_nxt};
            {gcrst_r, wchk_r, rec_p_r} <= {gcrst_nxt, wchk_nxt, rec_p_nxt};
        end
    end

    // ------------------------------------------------------------
    // reset, commands and status
    // ------------------------------------------------------------
    logic alert_r, alert_nxt, heat_r, heat_nxt, track_r, track_nxt, rflag_r, rflag_nxt;
    logic cerr_r, cerr_nxt, werr_r, werr_nxt, rd_status_nxt, brk_r, brk_nxt;
    logic cal_r, cal_nxt, leave_r, leave_nxt, fwd_r, fwd_nxt, wv_r, wv_nxt;
    logic [7:0] rcnt_r, rcnt_nxt;
    logic [5:0] pin_r, pin_nxt;
    logic [20:0] bcnt_r, bcnt_nxt;
    logic go_rst, exec, allowed;

    assign busy = rcnt_r != 8'h00;
    assign exec = done_r & ~busy;
    assign allowed = cmd_r == BREAK_CMD || cmd_r == FETCH_CMD ||
        cmd_r == `SCCU_CMD_READ_STATUS;

    // control next state
    always_comb begin
        alert_nxt = alert_r;
        heat_nxt = heat_r;
        track_nxt = track_r;
        rflag_nxt = rflag_r;
        cerr_nxt = cerr_r;
        werr_nxt = werr_r;
        rd_status_nxt = rd_status_r;
        brk_nxt = brk_r;
        bcnt_nxt = bcnt_r;
        rcnt_nxt = busy ? rcnt_r - 8'h01 : rcnt_r;
        pin_nxt = rstn_s2 ? 6'h00 : ((pin_r == PIN_CYC) ? pin_r : pin_r + 6'h01);
        go_rst = gcrst_r | (~rstn_s2 & pin_r >= PIN_CYC - 6'h01); // R3 R9 R10
        cal_nxt = meas_start_i; // R8
        leave_nxt = 1'b0;
        fwd_nxt = 1'b0;
        wv_nxt = 1'b0;
        if (wchk_r && !busy) begin
            werr_nxt = wcrc_r != rx_crc; // R18
            wv_nxt = wcrc_r == rx_crc;
        end
        if (exec) begin
            cerr_nxt = 1'b0; // R17
            if (periodic_i && !allowed) begin
                cerr_nxt = 1'b1; // R26
            end else if (cmd_r == BREAK_CMD) begin
                brk_nxt = 1'b1;
                bcnt_nxt = 21'h000000;
            end else if (cmd_r == `SCCU_CMD_SOFT_RESET) begin
                go_rst = go_rst | (~meas_busy_i & ~periodic_i); // R7
                cerr_nxt = meas_busy_i | periodic_i;
            end else if (cmd_r == `SCCU_CMD_HEATER_ON) begin
                heat_nxt = 1'b1; // R11
            end else if (cmd_r == `SCCU_CMD_HEATER_OFF) begin
                heat_nxt = 1'b0; // R11
            end else if (cmd_r == `SCCU_CMD_READ_STATUS) begin
                rd_status_nxt = 1'b1; // R13
            end else if (cmd_r == `SCCU_CMD_CLEAR_STATUS) begin
                {alert_nxt, track_nxt, rflag_nxt} = 3'h0; // R14
            end else begin
                rd_status_nxt = 1'b0;
                fwd_nxt = 1'b1;
            end
        end
        // break waits for running measurement, bounded
        if (brk_r) begin
            if (!meas_busy_i || bcnt_r == BRK_LAST) begin
                brk_nxt = 1'b0; // R1
                leave_nxt = 1'b1;
            end else begin
                bcnt_nxt = bcnt_r + 21'h000001;
            end
        end
        // hardware events win over a clear in the same cycle
        if (track_alert_i) begin
            track_nxt = 1'b1;
        end
        if (alert_i || track_alert_i) begin
            alert_nxt = 1'b1; // R15
        end
        if (go_rst) begin
            rcnt_nxt = RST_LEN;
            heat_nxt = 1'b0; // R12
            alert_nxt = 1'b1; // R15
            rflag_nxt = 1'b1; // R16
            {track_nxt, cerr_nxt, werr_nxt, rd_status_nxt, brk_nxt} = 5'h00;
            cal_nxt = rstn_s2 | (pin_r != PIN_CYC); // R7
            fwd_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rcnt_r <= RST_LEN; // R3
            pin_r <= 6'h00;
            bcnt_r <= 21'h000000;
            {alert_r, heat_r, track_r, rflag_r} <= 4'h9;
            {cerr_r, werr_r, rd_status_r, brk_r} <= 4'h0;
            {cal_r, leave_r, fwd_r, wv_r} <= 4'h0;
        end else if (ce_i) begin
            rcnt_r <= rcnt_nxt;
            pin_r <= pin_nxt;
            bcnt_r <= bcnt_nxt;
            {alert_r, heat_r, track_r, rflag_r} <= {alert_nxt, heat_nxt, track_nxt, rflag_nxt};
            {cerr_r, werr_r, rd_status_r, brk_r} <= {cerr_nxt, werr_nxt, rd_status_nxt, brk_nxt};
            {cal_r, leave_r, fwd_r, wv_r} <= {cal_nxt, leave_nxt, fwd_nxt, wv_nxt};
        end
    end

    // status word, reserved bits zero
    always_comb begin
        status_o = 16'h0000; // R19
        status_o[`SCCU_ST_ALERT] = alert_r;
        status_o[`SCCU_ST_HEATER] = heat_r; // R12
        status_o[`SCCU_ST_TRACK] = track_r;
        status_o[`SCCU_ST_RESET] = rflag_r;
        status_o[`SCCU_ST_CMD] = cerr_r;
        status_o[`SCCU_ST_WCRC] = werr_r;
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drv_r;
    assign heater_on_o = heat_r;
    assign sys_reset_o = busy;
    assign cal_reload_o = cal_r;
    assign leave_periodic_o = leave_r;
    assign intf_reset_o = rec_p_r;
    assign cmd_o = cmd_r;
    assign cmd_valid_o = fwd_r;
    assign wr_word_o = data_r;
    assign wr_valid_o = wv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || !ce_i);

    heater_on_a: assert property (exec && cmd_r == `SCCU_CMD_HEATER_ON && !periodic_i // R11
        && !go_rst |=> heater_on_o) else $error("heater did not switch on");
    clear_flags_a: assert property (exec && cmd_r == `SCCU_CMD_CLEAR_STATUS && !go_rst // R14
        && !alert_i && !track_alert_i |=> status_o[15] == 1'b0 && status_o[10] == 1'b0
        && status_o[4] == 1'b0) else $error("clear status left a flag set");
    reset_state_a: assert property (go_rst |=> !heater_on_o && status_o[4] // R16
        && status_o[15] && sys_reset_o) else $error("reset state wrong");
    busy_nack_a: assert property (st_r == SCCU_ADDR && scl_fall && bit_r == 4'h8 && busy // R4
        && !bus_start && !bus_stop |=> !drv_r) else $error("address acked during reset");
    recover_keep_a: assert property (rec_p_nxt && !alert_i && !track_alert_i && !go_rst // R6
        && !exec && !wchk_r |=> $stable(status_o)) else $error("recovery touched status");
    break_bound_a: assert property (brk_r |-> bcnt_r <= BRK_LAST) // R1
        else $error("break wait overran");
    nack_stop_a: assert property (st_r == SCCU_TX_ACK && scl_rise && sda_s2 && !bus_start // R24
        && rec_r != REC_LAST |=> st_r == SCCU_SKIP ##1 !drv_r) else $error("sent after nack");
    pin_reset_a: assert property (!rstn_s2 && pin_r == PIN_CYC - 6'h01 // R10
        |=> sys_reset_o [*2]) else $error("pin reset not taken");
    short_cmd_a: assert property (bus_stop && st_r == SCCU_RX && idx_r < 3'h2 // R25
        |=> !done_r ##1 !cmd_valid_o) else $error("partial command executed");
    reserved_zero_a: assert property ((status_o & 16'h5bec) == 16'h0000) // R19
        else $error("reserved status bit set");
endmodule : sccu_core

// ---- dv/sccu_master.sv ----
`timescale 1ns/1ps
// ------------------------------
// i2c master partner model
// ------------------------------
module sccu_master (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    // start or repeated start: data falls while clock high
    task automatic start();
        sda_low_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
        tick(2);
    endtask : start
    // nine bits, msb first; data changes only while clock low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o <= ~tx[i];
            tick(2);
            scl_o <= 1'b1;
            tick(3);
            rx[i] = sda_i;
            tick(1);
            scl_o <= 1'b0;
            tick(2);
        end
    endtask : xfer
    // stop: data rises while clock high, bus left idle
    task automatic stop();
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(4);
    endtask : stop
    // nine clock pulses with data released, then back to idle
    task automatic recover();
        logic [8:0] rx;
        scl_o <= 1'b0;
        tick(2);
        xfer(9'h1ff, rx);
        stop();
    endtask : recover
endmodule : sccu_master

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "sccu_regs.svh"
// ------------------------------
// command unit bench
// ------------------------------
module tb;
    logic clk, rst, per, busy, mst, alrt, trk, xrst_n, sdo, oe_n, scl, mlow;
    logic heat, srst, leave, irst, cal, nk, cv, wv;
    logic [15:0] temp, st, wrw, cmdo;
    int n_fwd = 0, n_wv = 0;
    logic [23:0] rdv;
    logic [31:0] seed = 32'h67738eb1;
    int miscompares = 0, num_checks = 0, cyc = 0, n_cal = 0, n_leave = 0, n_irst = 0, c0;
    wire sda = ~mlow & (oe_n | sdo); // pulled-up open-drain wire
    sccu_core #(.RST_DUR(255), .BREAK_CYC(50)) dut (
        .mclk_i(clk), .rst_i(rst), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
        .sda_o(sdo), .sda_oe_n_o(oe_n), .ext_reset_low_i(xrst_n), .periodic_i(per),
        .meas_busy_i(busy), .meas_start_i(mst), .alert_i(alrt), .track_alert_i(trk),
        .temp_word_i(temp), .status_o(st), .heater_on_o(heat), .sys_reset_o(srst),
        .cal_reload_o(cal), .leave_periodic_o(leave), .intf_reset_o(irst), .cmd_o(cmdo),
        .cmd_valid_o(cv), .wr_word_o(wrw), .wr_valid_o(wv));
    sccu_master m (.mclk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(mlow));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_cal <= n_cal + int'(cal === 1'b1);
        n_leave <= n_leave + int'(leave === 1'b1);
        n_irst <= n_irst + int'(irst === 1'b1);
        n_fwd <= n_fwd + int'(cv === 1'b1);
        n_wv <= n_wv + int'(wv === 1'b1);
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = `SCCU_CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `SCCU_CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write transfer of n bytes after the header
    task automatic wr(input logic [7:0] hdr, input logic [39:0] v, input int n);
        logic [8:0] rx;
        m.start();
        m.xfer({hdr, 1'b1}, rx);
        nk = rx[0];
        for (int i = 0; i < n; i++) begin
            m.xfer({v[39 - 8 * i -: 8], 1'b1}, rx);
            nk = nk | rx[0];
        end
        m.stop();
    endtask : wr
    task automatic cmd(input logic [15:0] c);
        wr(8'h8a, {c, 24'h0}, 2);
    endtask : cmd
    // three-byte read, nack on the last
    task automatic rd();
        logic [8:0] rx;
        m.start();
        m.xfer(9'h117, rx);
        for (int i = 0; i < 3; i++) begin
            m.xfer({8'hff, i == 2}, rx);
            rdv = {rdv[15:0], rx[8:1]};
        end
        m.stop();
    endtask : rd
    task automatic after_rst();
        chk("reset busy", 16'h1, {15'h0, srst});
        repeat (4) @(posedge clk);
        for (int i = 0; i < 800 && srst !== 1'b0; i++) @(posedge clk);
        chk("reset status", 16'h8010, st);
        chk("heater off", 16'h0, {15'h0, heat});
    endtask : after_rst
    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        rst = 1'b1;
        {per, busy, mst, alrt, trk} = 5'h0;
        xrst_n = 1'b1;
        temp = 16'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        cmd(16'h306d);
        chk("nack in reset", 16'h1, {15'h0, nk});
        after_rst();
        cmd(16'hf32d);
        chk("ack", 16'h0, {15'h0, nk});
        rd();
        chk("status word", 16'h8010, rdv[23:8]);
        chk("status crc", {8'h0, crc8(16'h8010)}, {8'h0, rdv[7:0]});
        for (int k = 0; k < 2; k++) begin
            if (k == 0) trk <= 1'b1;
            else alrt <= 1'b1;
            @(posedge clk);
            {alrt, trk} <= 2'h0;
            repeat (4) @(posedge clk);
            chk("alert", k ? 16'h8000 : 16'h8410, st);
            cmd(16'h3041);
            chk("cleared", 16'h0, st);
        end
        for (int k = 0; k < 7; k++) begin
            seed = xs(seed);
            temp <= seed[31:16];
            cmd((seed[0] || k == 6) ? 16'h306d : 16'h3066);
            chk("heater bit", {2'h0, seed[0] | (k == 6), 13'h0}, st);
        end
        wr(8'h8a, {16'h3066, 24'h0}, 1);
        chk("cut command", 16'h2000, st);
        seed = xs(seed);
        wr(8'h8a, {16'h2130, seed[15:0], crc8(seed[15:0])}, 5);
        chk("write word", seed[15:0], wrw);
        chk("good crc", 16'h2000, st);
        wr(8'h8a, {16'h2130, seed[15:0], ~crc8(seed[15:0])}, 5);
        chk("bad crc", 16'h2001, st);
        chk("fwd count", 16'h2, 16'(n_fwd));
        chk("fwd command", 16'h2130, cmdo);
        chk("write valid", 16'h1, 16'(n_wv));
        rd();
        chk("temp word", temp, rdv[23:8]);
        chk("temp crc", {8'h0, crc8(temp)}, {8'h0, rdv[7:0]});
        per <= 1'b1;
        busy <= 1'b1;
        cmd(16'h3066);
        chk("periodic reject", 16'h2003, st);
        c0 = n_leave;
        cmd(16'h0001);
        chk("break early", 16'(c0), 16'(n_leave));
        repeat (60) @(posedge clk);
        chk("break done", 16'(c0 + 1), 16'(n_leave));
        chk("break ok", 16'h2001, st);
        {per, busy} <= 2'h0;
        c0 = n_irst;
        m.recover();
        chk("recovery", 16'(c0 + 1), 16'(n_irst));
        chk("recovery keeps", 16'h2001, st);
        c0 = n_cal;
        mst <= 1'b1;
        @(posedge clk);
        mst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("reload", 16'(c0 + 1), 16'(n_cal));
        for (int k = 0; k < 3; k++) begin
            cmd(16'h306d);
            cmd(16'h3041);
            c0 = n_cal;
            if (k == 0) cmd(16'h30a2);
            else if (k == 1) wr(8'h00, {8'h06, 32'h0}, 1);
            else begin
                xrst_n <= 1'b0;
                repeat (40) @(posedge clk);
                xrst_n <= 1'b1;
            end
            after_rst();
            chk("reset reload", 16'(c0 + 1), 16'(n_cal));
        end
        tally_and_finish();
    end
endmodule : tb
